// ==== rtl/registered_bidir_transceiver.sv ====
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"

module registered_bidir_transceiver import xcvr_pkg::*; #(
    parameter int LANES = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`XCVR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic inbound_mode_sel_hi,
    input wire logic inbound_mode_sel_lo,
    input wire logic outbound_mode_sel_hi,
    input wire logic outbound_mode_sel_lo,
    input wire logic to_bus_clock_or_latch_en,
    input wire logic from_bus_clock_or_latch_en,
    input wire logic local_loopback_en,
    input wire logic digital_side_out_en,
    input wire logic bus_side_out_en,
    input wire logic receiver_data_en,
    input wire logic [LANES-1:0] digital_data_in,
    output logic [LANES-1:0] digital_data_out,
    output logic digital_out_en_n,
    input wire logic [LANES-1:0] bus_pair_true_in,
    input wire logic [LANES-1:0] bus_pair_comp_in,
    output logic [LANES-1:0] bus_pair_true_out,
    output logic [LANES-1:0] bus_pair_comp_out,
    output logic bus_pair_out_en_n
);

    if (LANES < 1 || LANES > 32) begin : g_lane_check
        $error("LANES must lie between 1 and 32 to fit one register word");
    end

    mode_e in_raw;
    mode_e out_raw;
    logic bus_loop;
    dir_cfg_s in_cfg;
    dir_cfg_s out_cfg;
    logic [LANES-1:0] rx_raw;
    logic [LANES-1:0] rx_to_digital;
    logic [LANES-1:0] tx_q;
    logic [LANES-1:0] rx_q;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic iso_force;

    logic [LANES-1:0] loop_reg, loop_next;
    logic bus_loop_reg, bus_loop_next;
    logic [LANES-1:0] bus_data_reg, bus_data_next;
    logic [LANES-1:0] bus_comp_reg, bus_comp_next;
    logic [LANES-1:0] dig_data_reg, dig_data_next;
    logic dig_oe_n_reg, dig_oe_n_next;
    logic bus_oe_n_reg, bus_oe_n_next;

    // Mode decode: 11 on one side alone has no bus loop, so it stays a latch
    assign in_raw = decode_mode(inbound_mode_sel_hi, inbound_mode_sel_lo);
    assign out_raw = decode_mode(outbound_mode_sel_hi, outbound_mode_sel_lo);
    assign bus_loop = inbound_mode_sel_hi && inbound_mode_sel_lo
                      && outbound_mode_sel_hi && outbound_mode_sel_lo;

    always_comb begin
        in_cfg.strobe = from_bus_clock_or_latch_en;
        out_cfg.strobe = to_bus_clock_or_latch_en;
        if (bus_loop) begin
            in_cfg.mode = MODE_BUS_LOOP;
            out_cfg.mode = MODE_BUS_LOOP;
        end else begin
            in_cfg.mode = (in_raw == MODE_BUS_LOOP) ? MODE_LATCH : in_raw;
            out_cfg.mode = (out_raw == MODE_BUS_LOOP) ? MODE_LATCH : out_raw;
        end
    end

    // Receiver: equal legs (open or shorted pair) resolve low
    assign rx_raw = bus_pair_true_in & ~bus_pair_comp_in;
    // High receiver enable cuts the receiver off the digital path
    assign rx_to_digital = receiver_data_en ? '0 : rx_raw;

    assign iso_force = ctrl_word[`XCVR_CTRL_ISO_BIT];

    lane_store #(
        .LANES(LANES)
    ) u_to_bus_store (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cfg(out_cfg),
        .din(digital_data_in),
        .q(tx_q)
    );

    lane_store #(
        .LANES(LANES)
    ) u_from_bus_store (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cfg(in_cfg),
        .din(rx_to_digital),
        .q(rx_q)
    );

    // Bus loopback store: takes the bus word on entry and holds it for the stay
    always_comb begin
        bus_loop_next = bus_loop;
        loop_next = loop_reg;
        if (bus_loop && !bus_loop_reg) begin
            loop_next = rx_raw;
        end
    end

    // Output stage; stores feed it whether or not the pins drive
    always_comb begin
        case (out_cfg.mode)
            MODE_BUFFER: bus_data_next = digital_data_in;
            MODE_FLOP: bus_data_next = tx_q;
            MODE_LATCH: bus_data_next = to_bus_clock_or_latch_en ? digital_data_in : tx_q;
            default: bus_data_next = loop_reg;
        endcase
        bus_comp_next = ~bus_data_next;
        if (local_loopback_en) begin
            dig_data_next = digital_data_in;
        end else begin
            case (in_cfg.mode)
                MODE_BUFFER: dig_data_next = rx_to_digital;
                MODE_FLOP: dig_data_next = rx_q;
                MODE_LATCH: begin
                    dig_data_next = from_bus_clock_or_latch_en ? rx_to_digital : rx_q;
                end
                default: dig_data_next = rx_q;
            endcase
        end
        // Enables gate only the pins, never the stores
        dig_oe_n_next = !(digital_side_out_en && !iso_force);
        bus_oe_n_next = !(bus_side_out_en && !iso_force);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_reg <= {LANES{`XCVR_STORE_RST_BIT}};
            bus_loop_reg <= 1'b0;
            bus_data_reg <= {LANES{`XCVR_STORE_RST_BIT}};
            bus_comp_reg <= {LANES{!`XCVR_STORE_RST_BIT}};
            dig_data_reg <= {LANES{`XCVR_STORE_RST_BIT}};
            dig_oe_n_reg <= 1'b1;
            bus_oe_n_reg <= 1'b1;
        end else if (ce) begin
            loop_reg <= loop_next;
            bus_loop_reg <= bus_loop_next;
            bus_data_reg <= bus_data_next;
            bus_comp_reg <= bus_comp_next;
            dig_data_reg <= dig_data_next;
            dig_oe_n_reg <= dig_oe_n_next;
            bus_oe_n_reg <= bus_oe_n_next;
        end
    end

    assign bus_pair_true_out = bus_data_reg;
    assign bus_pair_comp_out = bus_comp_reg;
    assign bus_pair_out_en_n = bus_oe_n_reg;
    assign digital_data_out = dig_data_reg;
    assign digital_out_en_n = dig_oe_n_reg;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`XCVR_STAT_IN_MODE_LSB +: 2] = in_cfg.mode;
        status_word[`XCVR_STAT_OUT_MODE_LSB +: 2] = out_cfg.mode;
        status_word[`XCVR_STAT_LOCAL_LOOP_BIT] = local_loopback_en;
        status_word[`XCVR_STAT_DIG_OE_BIT] = !dig_oe_n_reg;
        status_word[`XCVR_STAT_BUS_OE_BIT] = !bus_oe_n_reg;
        status_word[`XCVR_STAT_RX_EN_BIT] = receiver_data_en;
        status_word[`XCVR_STAT_BUS_LOOP_BIT] = bus_loop_reg;
    end

    xcvr_apb_regs #(
        .LANES(LANES)
    ) u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .status_word(status_word),
        .tx_store(tx_q),
        .rx_store(rx_q),
        .loop_store(loop_reg),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ctrl(ctrl_word)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence loop_entry_s;
        ce && bus_loop && !bus_loop_reg;
    endsequence

    sequence loop_stay_s;
        ce && bus_loop;
    endsequence

    a2b_buffer_a: assert property (
        ce && out_cfg.mode == MODE_BUFFER |=> bus_pair_true_out == $past(digital_data_in)
        && bus_pair_comp_out == ~$past(digital_data_in))
        else $error("outbound buffer did not pass data through");

    b2a_flop_a: assert property (
        ce && !local_loopback_en && in_cfg.mode == MODE_FLOP
        |=> digital_data_out == $past(rx_q))
        else $error("inbound flip-flop output is not the stored word");

    a2b_latch_open_a: assert property (
        ce && out_cfg.mode == MODE_LATCH && to_bus_clock_or_latch_en
        |=> bus_pair_true_out == $past(digital_data_in) && tx_q == $past(digital_data_in))
        else $error("outbound latch not transparent while enabled");

    local_loop_a: assert property (
        ce && local_loopback_en |=> digital_data_out == $past(digital_data_in))
        else $error("local loopback did not return the digital inputs");

    bus_loop_capture_a: assert property (
        loop_entry_s |=> loop_reg == $past(rx_raw))
        else $error("bus loopback word not captured");

    bus_loop_hold_a: assert property (
        loop_stay_s ##1 loop_stay_s |=> $stable(loop_reg))
        else $error("bus loopback word not held");

    bus_loop_drive_a: assert property (
        loop_entry_s ##1 loop_stay_s |=> bus_pair_true_out == $past(loop_reg))
        else $error("bus loopback word not driven back");

    digital_oe_a: assert property (
        ce |=> digital_out_en_n == !$past(digital_side_out_en && !iso_force))
        else $error("digital enable not followed");

    bus_oe_a: assert property (
        ce |=> bus_pair_out_en_n == !$past(bus_side_out_en && !iso_force))
        else $error("bus enable not followed");

    isolation_a: assert property (
        ce && !digital_side_out_en && !bus_side_out_en
        |=> digital_out_en_n && bus_pair_out_en_n)
        else $error("a side drove during isolation");

    store_while_off_a: assert property (
        ce && in_cfg.mode == MODE_LATCH && from_bus_clock_or_latch_en && digital_out_en_n
        |=> rx_q == $past(rx_to_digital))
        else $error("inbound store stopped while outputs floated");

    fail_safe_a: assert property (
        bus_pair_true_in == bus_pair_comp_in |-> rx_raw == '0)
        else $error("equal receiver legs did not resolve low");

    freeze_a: assert property (
        !ce |=> $stable(bus_pair_true_out) && $stable(digital_data_out) && $stable(loop_reg))
        else $error("state moved while clock enable was low");

    b2a_buffer_a: assert property (
        ce && !local_loopback_en && in_cfg.mode == MODE_BUFFER
        |=> digital_data_out == $past(rx_to_digital))
        else $error("inbound buffer did not pass data through");

    a2b_flop_a: assert property (
        ce && out_cfg.mode == MODE_FLOP |=> bus_pair_true_out == $past(tx_q))
        else $error("outbound flip-flop output is not the stored word");

    b2a_latch_shut_a: assert property (
        ce && !local_loopback_en && in_cfg.mode == MODE_LATCH
        && !from_bus_clock_or_latch_en |=> digital_data_out == $past(rx_q))
        else $error("inbound latch output moved while closed");

    rx_gate_a: assert property (
        receiver_data_en |-> rx_to_digital == '0)
        else $error("receiver reached the digital path while cut off");

    pair_comp_a: assert property (
        bus_pair_comp_out == ~bus_pair_true_out)
        else $error("bus pair legs not complementary");

endmodule

`default_nettype wire

// ==== rtl/xcvr_consts.svh ====
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

`define XCVR_ADDR_W 12
`define XCVR_CTRL_OFS 12'h000
`define XCVR_STAT_OFS 12'h004
`define XCVR_TXQ_OFS 12'h008
`define XCVR_RXQ_OFS 12'h00C
`define XCVR_LOOPQ_OFS 12'h010

`define XCVR_CTRL_ISO_BIT 0
`define XCVR_CTRL_RST 32'h0000_0000
`define XCVR_RDATA_RST 32'h0000_0000
`define XCVR_STORE_RST_BIT 1'b0
`define XCVR_STROBE_RST 1'b1

`define XCVR_STAT_IN_MODE_LSB 0
`define XCVR_STAT_OUT_MODE_LSB 2
`define XCVR_STAT_LOCAL_LOOP_BIT 4
`define XCVR_STAT_DIG_OE_BIT 5
`define XCVR_STAT_BUS_OE_BIT 6
`define XCVR_STAT_RX_EN_BIT 7
`define XCVR_STAT_BUS_LOOP_BIT 8

`endif

// ==== rtl/xcvr_pkg.sv ====
package xcvr_pkg;

    typedef enum logic [1:0] {
        MODE_BUFFER,
        MODE_FLOP,
        MODE_LATCH,
        MODE_BUS_LOOP
    } mode_e;

    typedef struct packed {
        mode_e mode;
        logic strobe;
    } dir_cfg_s;

    function automatic mode_e decode_mode(input logic sel_hi, input logic sel_lo);
        mode_e m;
        m = MODE_BUFFER;
        if (sel_hi && sel_lo) begin
            m = MODE_BUS_LOOP;
        end else if (sel_hi) begin
            m = MODE_LATCH;
        end else if (sel_lo) begin
            m = MODE_FLOP;
        end
        return m;
    endfunction

endpackage

// ==== rtl/lane_store.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"

module lane_store import xcvr_pkg::*; #(
    parameter int LANES = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire dir_cfg_s cfg,
    input wire logic [LANES-1:0] din,
    output logic [LANES-1:0] q
);

    logic [LANES-1:0] q_reg;
    logic [LANES-1:0] q_next;
    logic strobe_reg;
    logic strobe_next;
    logic rise;

    // Previous strobe resets high so a level held across reset is no edge
    assign rise = cfg.strobe && !strobe_reg;
    assign q = q_reg;

    always_comb begin
        strobe_next = cfg.strobe;
        q_next = q_reg;
        case (cfg.mode)
            MODE_FLOP: begin
                if (rise) begin
                    q_next = din;
                end
            end
            MODE_LATCH: begin
                if (cfg.strobe) begin
                    q_next = din;
                end
            end
            default: begin
                q_next = q_reg;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= {LANES{`XCVR_STORE_RST_BIT}};
            strobe_reg <= `XCVR_STROBE_RST;
        end else if (ce) begin
            q_reg <= q_next;
            strobe_reg <= strobe_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    flop_capture_a: assert property (
        ce && cfg.mode == MODE_FLOP && rise |=> q == $past(din))
        else $error("flip-flop store missed a rising strobe");
    latch_hold_a: assert property (
        ce && cfg.mode == MODE_LATCH && !cfg.strobe |=> $stable(q))
        else $error("latch store changed while closed");
    buffer_ignore_a: assert property (
        cfg.mode == MODE_BUFFER |=> $stable(q))
        else $error("store changed in buffer mode");

endmodule

`default_nettype wire

// ==== rtl/xcvr_apb_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"

module xcvr_apb_regs #(
    parameter int LANES = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`XCVR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] status_word,
    input wire logic [LANES-1:0] tx_store,
    input wire logic [LANES-1:0] rx_store,
    input wire logic [LANES-1:0] loop_store,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] ctrl
);

    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] ctrl_reg, ctrl_next;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ctrl = ctrl_reg;

    // Decode happens in the setup cycle so every answer leaves a flop
    always_comb begin
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        ctrl_next = ctrl_reg;
        if (psel && !penable) begin
            pready_next = 1'b1;
            prdata_next = `XCVR_RDATA_RST;
            if (paddr == `XCVR_CTRL_OFS) begin
                prdata_next = ctrl_reg;
            end else if (paddr == `XCVR_STAT_OFS && !pwrite) begin
                prdata_next = status_word;
            end else if (paddr == `XCVR_TXQ_OFS && !pwrite) begin
                prdata_next = 32'(tx_store);
            end else if (paddr == `XCVR_RXQ_OFS && !pwrite) begin
                prdata_next = 32'(rx_store);
            end else if (paddr == `XCVR_LOOPQ_OFS && !pwrite) begin
                prdata_next = 32'(loop_store);
            end else begin
                pslverr_next = 1'b1;
            end
        end else if (psel && penable && pready_reg) begin
            if (pwrite && !pslverr_reg && paddr == `XCVR_CTRL_OFS) begin
                ctrl_next = pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= `XCVR_RDATA_RST;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            ctrl_reg <= `XCVR_CTRL_RST;
        end else if (ce) begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            ctrl_reg <= ctrl_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_answer_a: assert property (
        ce && psel && !penable |=> pready)
        else $error("setup cycle not answered in the next cycle");
    apb_ctrl_write_a: assert property (
        ce && psel && penable && pready && pwrite && !pslverr && paddr == `XCVR_CTRL_OFS
        |=> ctrl == $past(pwdata))
        else $error("control write did not land");

endmodule

`default_nettype wire

// ==== bench/bus_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_partner #(
    parameter int LANES = 8
) (
    input wire logic pclk,
    input wire logic drive,
    input wire logic [LANES-1:0] word,
    input wire logic [1:0] lag,
    input wire logic [LANES-1:0] dut_true,
    input wire logic [LANES-1:0] dut_comp,
    input wire logic dut_en_n,
    output logic [LANES-1:0] line_true,
    output logic [LANES-1:0] line_comp
);
    logic [LANES-1:0] held = '0;
    logic [LANES-1:0] pat = '0;
    logic on = 1'b0;
    logic [1:0] wait_cnt = 2'b00;
    // A slow partner lets lag cycles pass before its first word reaches the pair
    always @(posedge pclk) begin
        pat <= ~pat;
        if (!drive) begin
            on <= 1'b0;
            wait_cnt <= lag;
        end else if (wait_cnt != 2'b00) begin
            wait_cnt <= wait_cnt - 2'b01;
        end else begin
            on <= 1'b1;
            held <= word;
        end
    end
    always_comb begin
        if (on) begin
            line_true = held;
            line_comp = ~held;
        end else if (!dut_en_n) begin
            line_true = dut_true;
            line_comp = dut_comp;
        end else begin
            // Floating pair: equal legs that change each cycle, never the last word
            line_true = pat;
            line_comp = pat;
        end
    end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.svh"
module testbench import xcvr_pkg::*;;
    localparam int WAIT = 7;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic inbound_mode_sel_hi = 1'b0, inbound_mode_sel_lo = 1'b0;
    logic outbound_mode_sel_hi = 1'b0, outbound_mode_sel_lo = 1'b0;
    logic to_bus_clock_or_latch_en = 1'b0, from_bus_clock_or_latch_en = 1'b0;
    logic local_loopback_en = 1'b0, digital_side_out_en = 1'b0, bus_side_out_en = 1'b0;
    logic receiver_data_en = 1'b0;
    logic [7:0] digital_data_in = 8'h00;
    logic [7:0] digital_data_out, bus_pair_true_in, bus_pair_comp_in;
    logic [7:0] bus_pair_true_out, bus_pair_comp_out, v, last;
    logic digital_out_en_n, bus_pair_out_en_n;
    logic drv = 1'b0;
    logic [7:0] drv_word = 8'h00;
    logic [1:0] lag = 2'b00;
    logic [12:0] refused [3] = '{{1'b0, 12'h014}, {1'b0, 12'h002}, {1'b1, 12'h004}};
    int seed = 21;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #12.5 pclk = ~pclk;

    registered_bidir_transceiver #(.LANES(8)) u_registered_bidir_transceiver (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .inbound_mode_sel_hi, .inbound_mode_sel_lo, .outbound_mode_sel_hi,
        .outbound_mode_sel_lo, .to_bus_clock_or_latch_en, .from_bus_clock_or_latch_en,
        .local_loopback_en, .digital_side_out_en, .bus_side_out_en, .receiver_data_en,
        .digital_data_in, .digital_data_out, .digital_out_en_n, .bus_pair_true_in,
        .bus_pair_comp_in, .bus_pair_true_out, .bus_pair_comp_out, .bus_pair_out_en_n);

    bus_partner #(.LANES(8)) u_bus_partner (.pclk, .drive(drv), .word(drv_word), .lag,
        .dut_true(bus_pair_true_out), .dut_comp(bus_pair_comp_out),
        .dut_en_n(bus_pair_out_en_n), .line_true(bus_pair_true_in),
        .line_comp(bus_pair_comp_in));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            $display("ERROR %0t run did not finish", $time);
            conclude();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] status_exp(input mode_e im, input mode_e om,
                                               input logic [3:0] f);
        return {24'h00_0000, f, 2'(om), 2'(im)};
    endfunction

    // Entered just after an edge; an idle cycle at the end keeps psel from two writes at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk1(n == 1, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Direction 0 is digital to bus, 1 is bus to digital
    task automatic cfg(input bit dir, input logic [1:0] m, input logic stb, input logic oe,
                       input logic [7:0] w);
        if (dir) begin
            {inbound_mode_sel_hi, inbound_mode_sel_lo} <= m;
            from_bus_clock_or_latch_en <= stb;
            digital_side_out_en <= oe;
            drv_word <= w;
        end else begin
            {outbound_mode_sel_hi, outbound_mode_sel_lo} <= m;
            to_bus_clock_or_latch_en <= stb;
            bus_side_out_en <= oe;
            digital_data_in <= w;
        end
        repeat (WAIT) @(posedge pclk);
    endtask

    task automatic see(input bit dir, input logic [7:0] e);
        if (dir) begin
            chk8(digital_data_out, e);
        end else begin
            chk8(bus_pair_true_out, e);
            chk8(bus_pair_comp_out, ~e);
        end
    endtask

    task automatic run_dir(input bit dir, output logic [7:0] fin);
        logic [7:0] a, b, c;
        a = 8'($random(seed));
        b = 8'($random(seed));
        c = ~a;
        cfg(dir, 2'b00, 1'b0, 1'b1, a);
        see(dir, a);
        chk1(dir ? digital_out_en_n : bus_pair_out_en_n, 1'b0);
        cfg(dir, 2'b00, 1'b1, 1'b1, b);
        see(dir, b);
        cfg(dir, 2'b01, 1'b0, 1'b1, b);
        cfg(dir, 2'b01, 1'b0, 1'b1, c);
        cfg(dir, 2'b01, 1'b1, 1'b1, c);
        see(dir, c);
        cfg(dir, 2'b01, 1'b1, 1'b1, a);
        see(dir, c);
        cfg(dir, 2'b01, 1'b0, 1'b0, b);
        chk1(dir ? digital_out_en_n : bus_pair_out_en_n, 1'b1);
        cfg(dir, 2'b01, 1'b1, 1'b0, b);
        cfg(dir, 2'b01, 1'b1, 1'b1, a);
        see(dir, b);
        {to_bus_clock_or_latch_en, from_bus_clock_or_latch_en} <= dir ? 2'b01 : 2'b10;
        repeat (2) @(posedge pclk);
        {to_bus_clock_or_latch_en, from_bus_clock_or_latch_en} <= 2'b11;
        repeat (WAIT) @(posedge pclk);
        see(dir, b);
        cfg(dir, 2'b10, 1'b1, 1'b1, c);
        see(dir, c);
        cfg(dir, 2'b10, 1'b0, 1'b1, c);
        cfg(dir, 2'b10, 1'b0, 1'b1, a);
        see(dir, c);
        cfg(dir, 2'b10, 1'b1, 1'b1, a);
        see(dir, a);
        fin = a;
        $display("test direction %0d done", dir);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        see(1'b0, 8'h00);
        see(1'b1, 8'h00);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, `XCVR_TXQ_OFS + 12'(4 * i), 32'h0000_0000);
            chk32(rd, 32'h0000_0000);
        end
        $display("test reset done");
        repeat (8) begin
            {inbound_mode_sel_hi, inbound_mode_sel_lo, outbound_mode_sel_hi, outbound_mode_sel_lo,
             to_bus_clock_or_latch_en, from_bus_clock_or_latch_en, local_loopback_en,
             receiver_data_en} <= 8'($random(seed));
            digital_data_in <= 8'($random(seed));
            repeat (3) @(posedge pclk);
            chk1(digital_out_en_n, 1'b1);
            chk1(bus_pair_out_en_n, 1'b1);
        end
        {to_bus_clock_or_latch_en, from_bus_clock_or_latch_en, local_loopback_en,
         receiver_data_en} <= 4'h0;
        $display("test isolation done");
        run_dir(1'b0, last);
        ce <= 1'b0;
        digital_data_in <= ~last;
        repeat (WAIT) @(posedge pclk);
        chk8(bus_pair_true_out, last);
        ce <= 1'b1;
        lag <= 2'($random(seed));
        repeat (WAIT) @(posedge pclk);
        see(1'b0, ~last);
        $display("test clock enable done");
        bus_side_out_en <= 1'b0;
        drv <= 1'b1;
        run_dir(1'b1, last);
        drv <= 1'b0;
        {inbound_mode_sel_hi, inbound_mode_sel_lo} <= 2'b00;
        repeat (WAIT) @(posedge pclk);
        chk8(digital_data_out, 8'h00);
        receiver_data_en <= 1'b1;
        local_loopback_en <= 1'b1;
        repeat (4) begin
            v = 8'($random(seed));
            digital_data_in <= v;
            repeat (WAIT) @(posedge pclk);
            chk8(digital_data_out, v);
        end
        local_loopback_en <= 1'b0;
        $display("test local loop done");
        v = 8'($random(seed));
        drv <= 1'b1;
        drv_word <= v;
        repeat (WAIT) @(posedge pclk);
        {inbound_mode_sel_hi, inbound_mode_sel_lo, outbound_mode_sel_hi,
         outbound_mode_sel_lo} <= 4'hF;
        repeat (WAIT) @(posedge pclk);
        drv_word <= ~v;
        repeat (WAIT) @(posedge pclk);
        drv <= 1'b0;
        bus_side_out_en <= 1'b1;
        repeat (WAIT) @(posedge pclk);
        see(1'b0, v);
        $display("test bus loop done");
        {inbound_mode_sel_hi, inbound_mode_sel_lo, outbound_mode_sel_hi,
         outbound_mode_sel_lo} <= 4'b0110;
        local_loopback_en <= 1'b1;
        bus_side_out_en <= 1'b0;
        repeat (WAIT) @(posedge pclk);
        apb(1'b0, `XCVR_STAT_OFS, 32'h0000_0000);
        chk32(rd, status_exp(MODE_FLOP, MODE_LATCH, 4'b1011));
        chk1(err, 1'b0);
        bus_side_out_en <= 1'b1;
        apb(1'b1, `XCVR_CTRL_OFS, 32'h0000_0001);
        repeat (WAIT) @(posedge pclk);
        chk1(digital_out_en_n & bus_pair_out_en_n, 1'b1);
        apb(1'b0, `XCVR_CTRL_OFS, 32'h0000_0000);
        chk32(rd, 32'h0000_0001);
        apb(1'b1, `XCVR_CTRL_OFS, 32'h0000_0000);
        repeat (WAIT) @(posedge pclk);
        chk1(digital_out_en_n | bus_pair_out_en_n, 1'b0);
        for (int i = 0; i < 3; i++) begin
            apb(refused[i][12], refused[i][11:0], 32'hFFFF_FFFF);
            chk1(err, 1'b1);
            chk32(rd, 32'h0000_0000);
        end
        $display("test registers done");
        conclude();
    end
endmodule
`default_nettype wire
